/* File: shared/imc_pkg.sv */
// constants shared by the programming-mode pin controller and its test port
`default_nettype none
package imc_pkg;
  // user pin count and boundary-scan chain layout (two cells per pin)
  localparam int N_PINS = 8;
  localparam int BS_LEN = 2 * N_PINS;
  localparam int BS_DATA_OFS = 0;
  localparam int BS_OE_OFS = 1;

  // instruction register; opcode values are arbitrary
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
  localparam logic [IR_W-1:0] IR_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] IR_EXTEST = 10'h00f;
  localparam logic [IR_W-1:0] IR_PROG_NORM = 10'h0a0;
  localparam logic [IR_W-1:0] IR_PROG_BG = 10'h0a1;
  localparam logic [IR_W-1:0] IR_PROG_CLAMP = 10'h0a2;
  localparam logic [IR_W-1:0] IR_BYPASS = 10'h3ff;

  // timing: system clock rate and power-up configuration delay
  localparam int CLK_MHZ = 50;
  localparam int T_CONFIG_US = 300;
  localparam int T_CONFIG_CYC = T_CONFIG_US * CLK_MHZ;
  localparam int WAIT_W = 20;
  localparam logic [2:0] RESET_CYC = 3'h4;

  // instructions that place the boundary-scan chain between tdi and tdo
  function automatic logic on_chain(input logic [IR_W-1:0] code);
    return (code == IR_SAMPLE) || (code == IR_EXTEST) ||
           (code == IR_PROG_CLAMP);
  endfunction
endpackage
`default_nettype wire

/* File: rtl/imc_tap_ctrl.sv */
// test port controller: pin sampling, state machine, instruction register
`default_nettype none
module imc_tap_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic dr_sout,
  output logic tdo_out,
  output logic tdo_oe_n,
  output logic [imc_pkg::IR_W-1:0] ir,
  output logic ir_load,
  output logic cap_dr,
  output logic sh_dr,
  output logic upd_dr,
  output logic tdi_bit
);
  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR,
    T_EX2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR,
    T_EX2_IR, T_UPD_IR
  } imc_tap_e;

  imc_tap_e state;
  imc_tap_e next_state;
  logic tck_s1, tck_s2, tck_s3;
  logic tms_s1, tms_s2;
  logic tdi_s1, tdi_s2;
  logic tck_rise, tck_fall;
  logic [imc_pkg::IR_W-1:0] ir_sh;
  logic bypass_bit;

  //////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; the third tck flop only serves edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hf;
    end else begin
      {tck_s3, tck_s2, tck_s1} <= {tck_s2, tck_s1, tck};
      {tms_s2, tms_s1} <= {tms_s1, tms};
      {tdi_s2, tdi_s1} <= {tdi_s1, tdi};
    end
  end

  assign tck_rise = tck_s2 && !tck_s3;
  assign tck_fall = !tck_s2 && tck_s3;
  // strobes act on the rising test-clock edge
  assign cap_dr = tck_rise && (state == T_CAP_DR);
  assign sh_dr = tck_rise && (state == T_SH_DR);
  assign upd_dr = tck_rise && (state == T_UPD_DR);
  assign tdi_bit = tdi_s2;

  // standard sixteen-state walk steered by mode-select
  always_comb begin
    case (state)
      T_RESET: next_state = tms_s2 ? T_RESET : T_IDLE;
      T_IDLE: next_state = tms_s2 ? T_SEL_DR : T_IDLE;
      T_SEL_DR: next_state = tms_s2 ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: next_state = tms_s2 ? T_EX1_DR : T_SH_DR;
      T_SH_DR: next_state = tms_s2 ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: next_state = tms_s2 ? T_UPD_DR : T_PA_DR;
      T_PA_DR: next_state = tms_s2 ? T_EX2_DR : T_PA_DR;
      T_EX2_DR: next_state = tms_s2 ? T_UPD_DR : T_SH_DR;
      T_UPD_DR: next_state = tms_s2 ? T_SEL_DR : T_IDLE;
      T_SEL_IR: next_state = tms_s2 ? T_RESET : T_CAP_IR;
      T_CAP_IR: next_state = tms_s2 ? T_EX1_IR : T_SH_IR;
      T_SH_IR: next_state = tms_s2 ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: next_state = tms_s2 ? T_UPD_IR : T_PA_IR;
      T_PA_IR: next_state = tms_s2 ? T_EX2_IR : T_PA_IR;
      T_EX2_IR: next_state = tms_s2 ? T_UPD_IR : T_SH_IR;
      T_UPD_IR: next_state = tms_s2 ? T_SEL_DR : T_IDLE;
      default: next_state = T_RESET;
    endcase
  end

  // state and mode-select are sampled on the rising edge only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= T_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction register; ir_load marks the cycle the new code appears
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ir_sh <= imc_pkg::IR_BYPASS;
      ir <= imc_pkg::IR_BYPASS;
      ir_load <= 1'b0;
      bypass_bit <= 1'b0;
    end else begin
      ir_load <= tck_rise && (state == T_UPD_IR);
      if (tck_rise) begin
        case (state)
          T_RESET: ir <= imc_pkg::IR_BYPASS;
          T_CAP_IR: ir_sh <= imc_pkg::IR_CAPTURE;
          T_SH_IR: ir_sh <= {tdi_s2, ir_sh[imc_pkg::IR_W-1:1]};
          T_UPD_IR: ir <= ir_sh;
          T_CAP_DR: bypass_bit <= 1'b0;
          T_SH_DR: bypass_bit <= tdi_s2;
          default: ir <= ir;
        endcase
      end
    end
  end

  // serial output moves on the falling edge, half a clock behind
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n <= !((state == T_SH_IR) || (state == T_SH_DR));
      if (state == T_SH_IR) begin
        tdo_out <= ir_sh[0];
      end else if (imc_pkg::on_chain(ir)) begin
        tdo_out <= dr_sout;
      end else begin
        tdo_out <= bypass_bit;
      end
    end
  end

  property p_tdo_on_fall;
    @(posedge sys_clk) disable iff (rst)
      (!$stable(tdo_out) || !$stable(tdo_oe_n)) |-> $past(tck_fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("serial output moved outside a falling test-clock edge");

  property p_state_on_rise;
    @(posedge sys_clk) disable iff (rst)
      !tck_rise |=> $stable(state);
  endproperty
  a_state_on_rise: assert property (p_state_on_rise)
    else $error("port state moved without a rising test-clock edge");
endmodule // imc_tap_ctrl
`default_nettype wire

/* File: rtl/imc_isp_mode_io_control.sv */
// pin and sequencing control for the three configuration programming modes
// Summary of operation
// - normal mode: copy config_flash into configuration memory after flashing.
// - normal mode: pins stay high impedance through flashing and the copy.
// - normal mode: after the copy, reset then run the new image.
// - normal mode: every pin tri-stated with weak pull-up to io_bank_supply.
// - background mode: user flash, logic and pins keep running.
// - background mode: no copy after flashing; old design keeps running.
// - background mode: new image takes effect only after a power cycle.
// - every power-up copies flash then enters user mode after config delay.
// - clamp mode: weak pull-ups off for the whole operation.
// - after extest, pins follow loaded scan values while clamp programming.
// - after clamp programming succeeds, pins are released to new design.
// - test port samples on rising tck, moves tdo on falling tck.
`default_nettype none
module imc_isp_mode_io_control #(
  parameter int T_CONFIG_CYC = imc_pkg::T_CONFIG_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe_n,
  input wire logic [imc_pkg::N_PINS-1:0] pin_in,
  output logic [imc_pkg::N_PINS-1:0] pin_out,
  output logic [imc_pkg::N_PINS-1:0] pin_oe_n,
  output logic [imc_pkg::N_PINS-1:0] pin_pullup_en,
  input wire logic [imc_pkg::N_PINS-1:0] user_out,
  input wire logic [imc_pkg::N_PINS-1:0] user_oe,
  output logic [imc_pkg::N_PINS-1:0] user_in,
  output logic user_run,
  output logic user_reset,
  output logic user_flash_block_en,
  output logic flash_prog_start,
  input wire logic flash_prog_done,
  input wire logic flash_prog_ok,
  output logic cfg_copy_start,
  input wire logic cfg_copy_done,
  output logic cfg_pending
);
  localparam int NP = imc_pkg::N_PINS;
  localparam int BL = imc_pkg::BS_LEN;

  typedef enum logic [3:0] {
    S_PWR_START, S_PWR_COPY, S_PWR_WAIT, S_USER, S_PROG_NORM, S_PROG_BG,
    S_PROG_CLAMP, S_COPY_NEW, S_RESET, S_BG_WAIT
  } imc_state_e;

  imc_state_e state;
  imc_state_e next_state;
  logic [imc_pkg::IR_W-1:0] ir;
  logic [imc_pkg::IR_W-1:0] prev_ir;
  logic ir_load, cap_dr, sh_dr, upd_dr, tdi_bit;
  logic [NP-1:0] pin_s1, pin_s2;
  logic [BL-1:0] bs_sh;
  logic [BL-1:0] bs_upd;
  logic [BL-1:0] bs_cap;
  logic [NP-1:0] upd_data, upd_oe;
  logic [imc_pkg::WAIT_W-1:0] wait_cnt;
  logic [2:0] rst_cnt;
  logic clamp_op;
  logic clamp_act;
  logic run_next;
  logic entering;

  //////////////////////////////////////////////////////////////////////////
  // test port
  imc_tap_ctrl u_tap (
    .sys_clk(sys_clk),
    .rst(rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .dr_sout(bs_sh[0]),
    .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n),
    .ir(ir),
    .ir_load(ir_load),
    .cap_dr(cap_dr),
    .sh_dr(sh_dr),
    .upd_dr(upd_dr),
    .tdi_bit(tdi_bit)
  );

  //////////////////////////////////////////////////////////////////////////
  // pad inputs come from another domain, so two flops before any use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // user logic sees the pads only while it is running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      user_in <= '0;
    end else begin
      user_in <= user_run ? pin_s2 : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // boundary-scan cells: a data and an enable cell per pin
  generate
    for (genvar i = 0; i < NP; i++) begin : g_cell
      // capture takes the present pad level; hold-sampled pins rely on it
      assign bs_cap[2*i+imc_pkg::BS_DATA_OFS] = pin_s2[i];
      assign bs_cap[2*i+imc_pkg::BS_OE_OFS] = !pin_oe_n[i];
      assign upd_data[i] = bs_upd[2*i+imc_pkg::BS_DATA_OFS];
      assign upd_oe[i] = bs_upd[2*i+imc_pkg::BS_OE_OFS];
    end
  endgenerate

  // shift register runs lsb first toward the serial output
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bs_sh <= '0;
    end else if (imc_pkg::on_chain(ir)) begin
      if (cap_dr) begin
        bs_sh <= bs_cap;
      end else if (sh_dr) begin
        bs_sh <= {tdi_bit, bs_sh[BL-1:1]};
      end
    end
  end

  // update cells load only under preload or extest; reset value is all
  // zero, which leaves every pin tri-stated if clamped unloaded
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bs_upd <= '0;
    end else if (upd_dr && ((ir == imc_pkg::IR_SAMPLE) ||
                            (ir == imc_pkg::IR_EXTEST))) begin
      bs_upd <= bs_sh;
    end
  end

  // last instruction before the current one: clamp needs extest first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_ir <= imc_pkg::IR_BYPASS;
    end else if (ir_load) begin
      prev_ir <= ir;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_PWR_START: next_state = S_PWR_COPY;
      S_PWR_COPY: if (cfg_copy_done) next_state = S_PWR_WAIT;
      S_PWR_WAIT: if (wait_cnt == '0) next_state = S_USER;
      S_USER: begin
        if (ir_load && (ir == imc_pkg::IR_PROG_NORM)) begin
          next_state = S_PROG_NORM;
        end else if (ir_load && (ir == imc_pkg::IR_PROG_BG)) begin
          next_state = S_PROG_BG;
        end else if (ir_load && (ir == imc_pkg::IR_PROG_CLAMP) &&
                     (prev_ir == imc_pkg::IR_EXTEST)) begin
          next_state = S_PROG_CLAMP;
        end
      end
      // copy begins only after the flash reports success
      S_PROG_NORM: begin
        if (flash_prog_done) begin
          next_state = flash_prog_ok ? S_COPY_NEW : S_USER;
        end
      end
      // background success parks with the old design, no copy
      S_PROG_BG: begin
        if (flash_prog_done) begin
          next_state = flash_prog_ok ? S_BG_WAIT : S_USER;
        end
      end
      S_PROG_CLAMP: begin
        if (flash_prog_done) begin
          next_state = flash_prog_ok ? S_COPY_NEW : S_USER;
        end
      end
      S_COPY_NEW: if (cfg_copy_done) next_state = S_RESET;
      S_RESET: if (rst_cnt == '0) next_state = S_USER;
      // only a power cycle (rst) leaves this state
      S_BG_WAIT: next_state = S_BG_WAIT;
      default: next_state = S_PWR_START;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_PWR_START;
    end else begin
      state <= next_state;
    end
  end

  // config delay runs from power-up through the copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_cnt <= imc_pkg::WAIT_W'(T_CONFIG_CYC - 1);
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 1'b1;
    end
  end

  // internal reset length after loading a new image
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_cnt <= '0;
    end else if (state != S_RESET) begin
      rst_cnt <= imc_pkg::RESET_CYC - 3'h1;
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - 3'h1;
    end
  end

  // clamping lasts from entry until user mode resumes, on success or failure
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clamp_op <= 1'b0;
    end else if (next_state == S_PROG_CLAMP) begin
      clamp_op <= 1'b1;
    end else if (next_state == S_USER) begin
      clamp_op <= 1'b0;
    end
  end

  // hold the clamp across the instruction change that starts programming;
  // without the look-ahead the pads drop to user values for one cycle
  assign clamp_act = clamp_op || (next_state == S_PROG_CLAMP) ||
                     ((state == S_USER) && (ir == imc_pkg::IR_EXTEST));
  assign run_next = (next_state == S_USER) || (next_state == S_PROG_BG) ||
                    (next_state == S_BG_WAIT);
  assign entering = (next_state != state);

  // mode outputs; logic and user flash stay live in background
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      user_run <= 1'b0;
      user_flash_block_en <= 1'b0;
      user_reset <= 1'b1;
      cfg_pending <= 1'b0;
    end else begin
      user_run <= run_next;
      user_flash_block_en <= run_next;
      user_reset <= !run_next;
      cfg_pending <= (next_state == S_BG_WAIT);
    end
  end

  // one-cycle starts for the flash engine and the configuration copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_prog_start <= 1'b0;
      cfg_copy_start <= 1'b0;
    end else begin
      flash_prog_start <= entering && ((next_state == S_PROG_NORM) ||
                          (next_state == S_PROG_BG) ||
                          (next_state == S_PROG_CLAMP));
      cfg_copy_start <= entering && ((next_state == S_PWR_COPY) ||
                        (next_state == S_COPY_NEW));
    end
  end

  // pad drivers: clamp values win, then user logic, else tri-state with
  // pull-up; pull-ups stay off under clamp even for tri-stated pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_pullup_en <= '1;
    end else if (clamp_act) begin
      pin_out <= upd_data;
      pin_oe_n <= ~upd_oe;
      pin_pullup_en <= '0;
    end else if (user_run) begin
      pin_out <= user_out;
      pin_oe_n <= ~user_oe;
      pin_pullup_en <= '0;
    end else begin
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_pullup_en <= '1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_copy_after_flash;
    @(posedge sys_clk) disable iff (rst)
      (state == S_PROG_NORM) && (next_state == S_COPY_NEW) |->
        flash_prog_done && flash_prog_ok ##1 cfg_copy_start;
  endproperty
  a_copy_after_flash: assert property (p_copy_after_flash)
    else $error("copy not started right after flash success");

  property p_norm_hiz;
    @(posedge sys_clk) disable iff (rst)
      (state == S_PROG_NORM || state == S_COPY_NEW) && !clamp_op ##1
        (state == S_PROG_NORM || state == S_COPY_NEW) |->
        (&pin_oe_n) && (&pin_pullup_en);
  endproperty
  a_norm_hiz: assert property (p_norm_hiz)
    else $error("pins driven or pull-up off during normal programming");

  property p_reset_then_run;
    @(posedge sys_clk) disable iff (rst)
      (state == S_COPY_NEW) && cfg_copy_done && !clamp_op |=>
        user_reset ##4 (state == S_USER) ##1 user_run && !user_reset;
  endproperty
  a_reset_then_run: assert property (p_reset_then_run)
    else $error("no reset then user run after copy");

  property p_bg_live;
    @(posedge sys_clk) disable iff (rst)
      (state == S_PROG_BG) |-> user_run && user_flash_block_en &&
        (pin_oe_n == ~$past(user_oe) || clamp_act || $past(clamp_act));
  endproperty
  a_bg_live: assert property (p_bg_live)
    else $error("user side stopped during background programming");

  property p_bg_no_copy;
    @(posedge sys_clk) disable iff (rst)
      (state == S_PROG_BG) && flash_prog_done && flash_prog_ok |=>
        (state == S_BG_WAIT) ##1 !cfg_copy_start && user_run && cfg_pending;
  endproperty
  a_bg_no_copy: assert property (p_bg_no_copy)
    else $error("background success did not park on old design");

  property p_bg_hold;
    @(posedge sys_clk) disable iff (rst)
      (state == S_BG_WAIT) |=> (state == S_BG_WAIT) && !cfg_copy_start;
  endproperty
  a_bg_hold: assert property (p_bg_hold)
    else $error("background wait left without a power cycle");

  property p_config_delay;
    @(posedge sys_clk) disable iff (rst)
      $rose(user_run) && $past(state == S_PWR_WAIT) |->
        $past(wait_cnt == '0);
  endproperty
  a_config_delay: assert property (p_config_delay)
    else $error("user mode entered before config delay");

  property p_clamp_pins;
    @(posedge sys_clk) disable iff (rst)
      clamp_act |=> (pin_oe_n == ~$past(upd_oe)) && (pin_pullup_en == '0)
        && (pin_out == $past(upd_data));
  endproperty
  a_clamp_pins: assert property (p_clamp_pins)
    else $error("clamped pins not driven from scan cells");

  property p_clamp_release;
    @(posedge sys_clk) disable iff (rst)
      (state == S_PROG_CLAMP) && flash_prog_done && flash_prog_ok |=>
        (state == S_COPY_NEW) && clamp_op ##[1:1000] !clamp_op && user_run;
  endproperty
  a_clamp_release: assert property (p_clamp_release)
    else $error("clamped pins not released after success");
endmodule // imc_isp_mode_io_control
`default_nettype wire

/* File: dv/imc_prog_model.sv */
// boundary-scan programmer model that clocks the test port
`default_nettype none
module imc_prog_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////
  // one test clock; tdo read just before the fall, a released tdo reads x
  task automatic bit_io(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    #79 o = tdo_oe_n ? 1'bx : tdo_out;
    #1 tck = 1'b0;
  endtask
  // five high mode bits reach test-logic-reset from anywhere, then idle
  task automatic reset_tap();
    logic o;
    repeat (5) bit_io(1'b1, ~tdi, o);
    bit_io(1'b0, ~tdi, o);
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [15:0] v,
                      output logic [15:0] q);
    logic o;
    q = '0;
    bit_io(1'b1, ~tdi, o);
    if (is_ir) bit_io(1'b1, ~tdi, o);
    bit_io(1'b0, ~tdi, o);
    bit_io(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) bit_io(i == n - 1, v[i], q[i]);
    bit_io(1'b1, ~tdi, o);
    bit_io(1'b0, ~tdi, o);
    tdi = ~tdi; // released data line does not keep its last value
  endtask
  task automatic ir(input logic [imc_pkg::IR_W-1:0] code,
                    output logic [imc_pkg::IR_W-1:0] q);
    logic [15:0] w;
    scan(1'b1, imc_pkg::IR_W, 16'(code), w);
    q = w[imc_pkg::IR_W-1:0];
  endtask
  task automatic dr(input logic [imc_pkg::BS_LEN-1:0] v,
                    output logic [imc_pkg::BS_LEN-1:0] q);
    scan(1'b0, imc_pkg::BS_LEN, v, q);
  endtask
endmodule // imc_prog_model
`default_nettype wire

/* File: dv/imc_isp_mode_io_control_tb.sv */
// testbench for the programming-mode pin controller in its three modes
`default_nettype none
module imc_isp_mode_io_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCFG = 20; // short config delay keeps the run brief
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, tdo_out, tdo_oe_n;
  logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, user_in;
  logic [7:0] pat = 8'h5a;
  logic [7:0] user_out = 8'h05;
  logic [7:0] user_oe = 8'h0f;
  logic user_run, user_reset, user_flash_block_en, flash_prog_start;
  logic cfg_copy_start, cfg_pending;
  logic flash_prog_done = 1'b0, flash_prog_ok = 1'b0, cfg_copy_done = 1'b0;
  int errors = 0, samples_checked = 0, copies = 0;
  // clock, floating-pad pattern and copy-start counter
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) pat <= ~pat;
  always @(posedge sys_clk) if (cfg_copy_start === 1'b1) copies <= copies + 1;
  // undriven pads go high on pull-up, else float to a moving pattern
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pullup_en | pat));
  imc_isp_mode_io_control #(.T_CONFIG_CYC(TCFG)) u_dut (
    .sys_clk, .rst, .tck, .tms, .tdi, .tdo_out, .tdo_oe_n, .pin_in,
    .pin_out, .pin_oe_n, .pin_pullup_en, .user_out, .user_oe, .user_in,
    .user_run, .user_reset, .user_flash_block_en, .flash_prog_start,
    .flash_prog_done, .flash_prog_ok, .cfg_copy_start, .cfg_copy_done,
    .cfg_pending
  );
  imc_prog_model u_prog (.tck, .tms, .tdi, .tdo_out, .tdo_oe_n);
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // bounded wait on a level or a one-cycle pulse seen at falling edges
  task automatic wait_hi(ref logic s, input int lim, input string msg);
    int k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    chk(s, 1'b1, msg);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic prog(input logic [imc_pkg::IR_W-1:0] code);
    logic [imc_pkg::IR_W-1:0] q;
    fork
      u_prog.ir(code, q);
      wait_hi(flash_prog_start, 400, "flash start");
    join
    chk(q, imc_pkg::IR_CAPTURE, "ir capture");
    cyc(2);
  endtask
  ////////////////////////////////////////
  task automatic power_up();
    wait_hi(cfg_copy_start, 10, "power-up copy");
    chk(pin_oe_n, 8'hff, "power-up tri");
    cyc(2);
    pulse(cfg_copy_done);
    chk(user_run, 1'b0, "run before delay");
    wait_hi(user_run, TCFG + 10, "user mode");
  endtask
  task automatic normal_prog();
    int c0 = copies;
    prog(imc_pkg::IR_PROG_NORM);
    chk(pin_oe_n, 8'hff, "norm tri");
    chk(pin_pullup_en, 8'hff, "norm pullup");
    chk(copies, c0, "copy too early");
    chk(user_reset, 1'b1, "norm user reset");
    flash_prog_ok = 1'b1;
    pulse(flash_prog_done);
    wait_hi(cfg_copy_start, 3, "norm copy");
    chk(pin_oe_n, 8'hff, "tri in copy");
    pulse(cfg_copy_done);
    wait_hi(user_run, 12, "norm restart");
    cyc(1);
    chk(pin_oe_n, 8'hf0, "new image pins");
  endtask
  // a failed flash goes back to the old image with no copy
  task automatic fail_prog();
    int c0 = copies;
    prog(imc_pkg::IR_PROG_NORM);
    flash_prog_ok = 1'b0;
    pulse(flash_prog_done);
    wait_hi(user_run, 3, "old image back");
    chk(copies, c0, "copy after failure");
    flash_prog_ok = 1'b1;
  endtask
  task automatic bg_prog();
    int c0 = copies;
    prog(imc_pkg::IR_PROG_BG);
    chk(user_run, 1'b1, "bg logic");
    chk(user_flash_block_en, 1'b1, "bg user flash");
    chk(pin_oe_n, 8'hf0, "bg pin enables");
    chk(pin_out & 8'h0f, 8'h05, "bg pin data");
    chk(user_in & 8'h0f, 8'h05, "bg user pads");
    chk(user_reset, 1'b0, "bg user reset");
    pulse(flash_prog_done);
    cyc(3);
    chk(cfg_pending, 1'b1, "bg pending");
    chk(copies, c0, "bg copied");
    chk(user_run, 1'b1, "bg old design");
    rst = 1'b1; // power cycle
    cyc(5);
    rst = 1'b0;
    chk(cfg_pending, 1'b0, "pending after cycle");
    power_up();
    u_prog.reset_tap();
  endtask
  // pins 0..5 clamped to alternating levels, pins 6..7 left high-z
  task automatic clamp_prog();
    logic [15:0] ch, q;
    logic [imc_pkg::IR_W-1:0] qi;
    for (int i = 0; i < 8; i++) begin
      ch[2*i] = i[0];
      ch[2*i+1] = (i < 6);
    end
    u_prog.ir(imc_pkg::IR_SAMPLE, qi);
    u_prog.dr(ch, q);
    chk(q & 16'haaff, 16'h00bb, "capture");
    u_prog.ir(imc_pkg::IR_EXTEST, qi);
    cyc(3);
    chk(pin_oe_n, 8'hc0, "clamp enables");
    chk(pin_out & 8'h3f, 8'h2a, "clamp data");
    chk(pin_pullup_en, 8'h00, "clamp pullup");
    prog(imc_pkg::IR_PROG_CLAMP);
    chk(pin_oe_n, 8'hc0, "clamp in flash");
    chk(pin_pullup_en, 8'h00, "pullup in flash");
    pulse(flash_prog_done);
    wait_hi(cfg_copy_start, 3, "clamp copy");
    chk(pin_oe_n, 8'hc0, "clamp in copy");
    chk(pin_pullup_en, 8'h00, "pullup in copy");
    pulse(cfg_copy_done);
    wait_hi(user_run, 12, "clamp restart");
    cyc(2);
    chk(pin_oe_n, 8'hf0, "clamp release");
  endtask
  ////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence after a five-cycle reset
  initial begin
    cyc(5);
    rst = 1'b0;
    power_up();
    u_prog.reset_tap();
    normal_prog();
    fail_prog();
    bg_prog();
    clamp_prog();
    summarize();
  end
  // watchdog: about eighteen times the expected run
  initial begin
    #400000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule // imc_isp_mode_io_control_tb
`default_nettype wire
